// File: verilog/default_working_reg_map_pkg.sv
// Contract
// - prefetch DSP operands implied from W4..W7
// - prefetch address pointers are W8..W11
// - W12 supplies prefetch offset index
// - W13 is accumulator write-back destination
// - fixed assignments only for prefetch group
// - sign-select 10 picks signedness per register
// - mixed mode: W4,W6 unsigned; W5,W7 signed
// - other accumulator ops take any register
// - W14 implied frame pointer for link/unlink
// - W15 implied stack pointer for stack ops
// - W14/W15 still usable as generic operands
// - sixteen working registers, 16 bits each
// - file-register ops default to W0
// - 17x17 product to even pair or accumulator
// - word file multiply: high W3, low W2
// - byte file multiply: W2 only, W3 kept
// - file multiply operands are unsigned
// - default moves carry byte or word via W0
// - byte file moves only by default forms
// - word file moves use any register
package default_working_reg_map_pkg;
  localparam int unsigned NUM_WREGS = 16;
  localparam int unsigned DEFAULT_WORKING_REG_W    = 16;
  localparam logic [3:0] W_DEFAULT  = 4'h0;
  localparam logic [3:0] W_PROD_LO  = 4'h2;
  localparam logic [3:0] W_PROD_HI  = 4'h3;
  localparam logic [3:0] W_MAC_OP0  = 4'h4;
  localparam logic [3:0] W_PF_X0    = 4'h8;
  localparam logic [3:0] W_PF_Y0    = 4'hA;
  localparam logic [3:0] W_PF_OFS   = 4'hC;
  localparam logic [3:0] W_MAC_WB   = 4'hD;
  localparam logic [3:0] W_FRAME    = 4'hE;
  localparam logic [3:0] W_STACK    = 4'hF;
  localparam logic [1:0] SIGN_MIXED = 2'h2;
  localparam logic [1:0] SIGN_UNS   = 2'h1;
  localparam logic [15:0] DEFAULT_WORKING_REG_RST  = 16'h0000;

  typedef enum logic [4:0] {
    OP_NONE      = 5'h00,
    OP_CLR_ACC   = 5'h01,
    OP_EUCLID    = 5'h02,
    OP_EUCLID_AC = 5'h03,
    OP_MAC       = 5'h04,
    OP_PF_MOVE   = 5'h05,
    OP_DSP_MPY   = 5'h06,
    OP_MPY_NEG   = 5'h07,
    OP_MPY_SUB   = 5'h08,
    OP_ACC_GEN   = 5'h09,
    OP_FILE_MUL  = 5'h0A,
    OP_MOV_F2W   = 5'h0B,
    OP_MOV_W2F   = 5'h0C,
    OP_MOV_F2WN  = 5'h0D,
    OP_MOV_WN2F  = 5'h0E,
    OP_MUL_WW    = 5'h0F,
    OP_STACK     = 5'h10,
    OP_FRAME     = 5'h11,
    OP_ALU_F     = 5'h12
  } op_class_t;
endpackage

// File: verilog/operand_sign_sel.sv
`timescale 1ns/10ps
`default_nettype none
module operand_sign_sel
(
  input  wire logic [1:0] sign_select,
  input  wire logic [3:0] src_a,
  input  wire logic [3:0] src_b,
  output logic            a_signed,
  output logic            b_signed
);
  // mixed mode: even operand registers unsigned, odd signed
  function automatic logic reg_signed(input logic [3:0] r);
    reg_signed = r[0];
  endfunction

  always_comb
  begin
    if (sign_select == default_working_reg_map_pkg::SIGN_MIXED)
    begin
      a_signed = reg_signed(src_a);
      b_signed = reg_signed(src_b);
    end
    else
    begin
      a_signed = (sign_select != default_working_reg_map_pkg::SIGN_UNS);
      b_signed = (sign_select != default_working_reg_map_pkg::SIGN_UNS);
    end
  end
endmodule
`default_nettype wire

// File: verilog/default_working_reg_operand_map.sv
`timescale 1ns/10ps
`default_nettype none
module default_working_reg_operand_map
(
  input  wire logic                   core_clk,
  input  wire logic                   rst_b,
  input  wire default_working_reg_map_pkg::op_class_t op_class,
  input  wire logic                   op_valid,
  input  wire logic                   byte_mode,
  input  wire logic [3:0]             wn_sel,
  input  wire logic [3:0]             wm_sel,
  input  wire logic [1:0]             mac_op_sel,
  input  wire logic [1:0]             pf_x_sel,
  input  wire logic [1:0]             pf_y_sel,
  input  wire logic [1:0]             mult_sign_select,
  input  wire logic [15:0]            file_rdata,
  input  wire logic [15:0]            wb_data,
  input  wire logic [15:0]            sp_next,
  input  wire logic                   sp_we,
  input  wire logic [15:0]            fp_next,
  input  wire logic                   fp_we,
  input  wire logic [3:0]             rd_sel,
  output logic [15:0]                 rd_data,
  output logic [15:0]                 file_wdata,
  output logic                        file_we,
  output logic                        file_byte,
  output logic                        op_a_signed,
  output logic                        op_b_signed,
  output logic [3:0]                  op_a_reg,
  output logic [3:0]                  op_b_reg,
  output logic [3:0]                  pf_x_reg,
  output logic [3:0]                  pf_y_reg,
  output logic [3:0]                  pf_ofs_reg,
  output logic [3:0]                  acc_wb_reg,
  output logic                        illegal_op
);
  logic       rst_s1_q;
  logic       rst_s2_q;
  logic [15:0] default_working_reg_q [default_working_reg_map_pkg::NUM_WREGS];
  logic [15:0] default_working_reg_d [default_working_reg_map_pkg::NUM_WREGS];
  logic [15:0] file_wdata_q;
  logic [15:0] file_wdata_d;
  logic        file_we_q;
  logic        file_we_d;
  logic        file_byte_q;
  logic        file_byte_d;
  logic        illegal_q;
  logic        illegal_d;
  logic        prefetch_grp;
  logic [31:0] prod;
  logic [3:0]  pair_lo;
  default_working_reg_map_pkg::op_class_t cls;

  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rst_s1_q <= 1'b0;
      rst_s2_q <= 1'b0;
    end
    else
    begin
      rst_s1_q <= 1'b1;
      rst_s2_q <= rst_s1_q;
    end
  end

  assign cls = op_valid ? op_class : default_working_reg_map_pkg::OP_NONE;

  always_comb
  begin
    case (cls)
      default_working_reg_map_pkg::OP_CLR_ACC, default_working_reg_map_pkg::OP_EUCLID, default_working_reg_map_pkg::OP_EUCLID_AC,
      default_working_reg_map_pkg::OP_MAC, default_working_reg_map_pkg::OP_PF_MOVE, default_working_reg_map_pkg::OP_DSP_MPY,
      default_working_reg_map_pkg::OP_MPY_NEG, default_working_reg_map_pkg::OP_MPY_SUB:
        prefetch_grp = 1'b1;
      default:
        prefetch_grp = 1'b0;
    endcase
  end

  // operand selection
  always_comb
  begin
    if (prefetch_grp)
    begin
      op_a_reg   = default_working_reg_map_pkg::W_MAC_OP0 + {2'h0, mac_op_sel[0], 1'b0};
      op_b_reg   = default_working_reg_map_pkg::W_MAC_OP0 + {2'h0, mac_op_sel[1], 1'b1};
      pf_x_reg   = default_working_reg_map_pkg::W_PF_X0 + {3'h0, pf_x_sel[0]};
      pf_y_reg   = default_working_reg_map_pkg::W_PF_Y0 + {3'h0, pf_y_sel[0]};
      pf_ofs_reg = default_working_reg_map_pkg::W_PF_OFS;
      acc_wb_reg = default_working_reg_map_pkg::W_MAC_WB;
    end
    else if (cls == default_working_reg_map_pkg::OP_FILE_MUL || cls == default_working_reg_map_pkg::OP_ALU_F ||
             cls == default_working_reg_map_pkg::OP_MOV_F2W || cls == default_working_reg_map_pkg::OP_MOV_W2F)
    begin
      op_a_reg   = default_working_reg_map_pkg::W_DEFAULT;
      op_b_reg   = default_working_reg_map_pkg::W_DEFAULT;
      pf_x_reg   = 4'h0;
      pf_y_reg   = 4'h0;
      pf_ofs_reg = 4'h0;
      acc_wb_reg = 4'h0;
    end
    else if (cls == default_working_reg_map_pkg::OP_STACK)
    begin
      op_a_reg   = default_working_reg_map_pkg::W_STACK;
      op_b_reg   = wn_sel;
      pf_x_reg   = 4'h0;
      pf_y_reg   = 4'h0;
      pf_ofs_reg = 4'h0;
      acc_wb_reg = 4'h0;
    end
    else if (cls == default_working_reg_map_pkg::OP_FRAME)
    begin
      op_a_reg   = default_working_reg_map_pkg::W_STACK;
      op_b_reg   = default_working_reg_map_pkg::W_FRAME;
      pf_x_reg   = 4'h0;
      pf_y_reg   = 4'h0;
      pf_ofs_reg = 4'h0;
      acc_wb_reg = 4'h0;
    end
    else
    begin
      op_a_reg   = wn_sel;
      op_b_reg   = wm_sel;
      pf_x_reg   = 4'h0;
      pf_y_reg   = 4'h0;
      pf_ofs_reg = 4'h0;
      acc_wb_reg = 4'h0;
    end
  end

  operand_sign_sel u_sign
  (
    .sign_select (mult_sign_select),
    .src_a       (op_a_reg),
    .src_b       (op_b_reg),
    .a_signed    (op_a_signed),
    .b_signed    (op_b_signed)
  );

  // file multiply is unsigned on both sides
  assign prod = byte_mode ?
                {16'h0000, {8'h00, file_rdata[7:0]} * {8'h00, default_working_reg_q[0][7:0]}} :
                {16'h0000, file_rdata} * {16'h0000, default_working_reg_q[0]};
  assign pair_lo = {wn_sel[3:1], 1'b0};

  always_comb
  begin
    for (int i = 0; i < default_working_reg_map_pkg::NUM_WREGS; i++)
    begin
      default_working_reg_d[i] = default_working_reg_q[i];
    end
    file_wdata_d = file_wdata_q;
    file_we_d    = 1'b0;
    file_byte_d  = 1'b0;
    illegal_d    = 1'b0;
    case (cls)
      default_working_reg_map_pkg::OP_FILE_MUL:
      begin
        default_working_reg_d[default_working_reg_map_pkg::W_PROD_LO] = prod[15:0];
        if (!byte_mode)
        begin
          default_working_reg_d[default_working_reg_map_pkg::W_PROD_HI] = prod[31:16];
        end
      end
      default_working_reg_map_pkg::OP_MUL_WW:
      begin
        default_working_reg_d[pair_lo]        = wb_data;
        default_working_reg_d[pair_lo + 4'h1] = file_rdata;
      end
      default_working_reg_map_pkg::OP_MOV_F2W:
      begin
        if (byte_mode)
        begin
          default_working_reg_d[0] = {default_working_reg_q[0][15:8], file_rdata[7:0]};
        end
        else
        begin
          default_working_reg_d[0] = file_rdata;
        end
      end
      default_working_reg_map_pkg::OP_MOV_W2F:
      begin
        file_wdata_d = byte_mode ? {8'h00, default_working_reg_q[0][7:0]} : default_working_reg_q[0];
        file_we_d    = 1'b1;
        file_byte_d  = byte_mode;
      end
      default_working_reg_map_pkg::OP_MOV_F2WN:
      begin
        if (byte_mode)
        begin
          illegal_d = 1'b1;
        end
        else
        begin
          default_working_reg_d[wn_sel] = file_rdata;
        end
      end
      default_working_reg_map_pkg::OP_MOV_WN2F:
      begin
        if (byte_mode)
        begin
          illegal_d = 1'b1;
        end
        else
        begin
          file_wdata_d = default_working_reg_q[wn_sel];
          file_we_d    = 1'b1;
        end
      end
      default_working_reg_map_pkg::OP_MAC, default_working_reg_map_pkg::OP_EUCLID_AC, default_working_reg_map_pkg::OP_MPY_SUB:
      begin
        default_working_reg_d[default_working_reg_map_pkg::W_MAC_WB] = wb_data;
      end
      default_working_reg_map_pkg::OP_ACC_GEN, default_working_reg_map_pkg::OP_ALU_F:
      begin
        default_working_reg_d[wm_sel] = wb_data;
      end
      default:
      begin
      end
    endcase
    if (sp_we)
    begin
      default_working_reg_d[default_working_reg_map_pkg::W_STACK] = sp_next;
    end
    if (fp_we)
    begin
      default_working_reg_d[default_working_reg_map_pkg::W_FRAME] = fp_next;
    end
  end

  always_ff @(posedge core_clk or negedge rst_s2_q)
  begin
    if (!rst_s2_q)
    begin
      for (int i = 0; i < default_working_reg_map_pkg::NUM_WREGS; i++)
      begin
        default_working_reg_q[i] <= default_working_reg_map_pkg::DEFAULT_WORKING_REG_RST;
      end
      file_wdata_q <= 16'h0000;
      file_we_q    <= 1'b0;
      file_byte_q  <= 1'b0;
      illegal_q    <= 1'b0;
    end
    else
    begin
      for (int i = 0; i < default_working_reg_map_pkg::NUM_WREGS; i++)
      begin
        default_working_reg_q[i] <= default_working_reg_d[i];
      end
      file_wdata_q <= file_wdata_d;
      file_we_q    <= file_we_d;
      file_byte_q  <= file_byte_d;
      illegal_q    <= illegal_d;
    end
  end

  assign rd_data    = default_working_reg_q[rd_sel];
  assign file_wdata = file_wdata_q;
  assign file_we    = file_we_q;
  assign file_byte  = file_byte_q;
  assign illegal_op = illegal_q;

  property p_pf_operands;
    @(posedge core_clk) disable iff (!rst_s2_q)
    prefetch_grp |-> (op_a_reg[3:2] == 2'h1) && (op_b_reg[3:2] == 2'h1);
  endproperty
  a_pf_operands: assert property (p_pf_operands) else $error("prefetch operand out of W4..W7");

  property p_pf_ptrs;
    @(posedge core_clk) disable iff (!rst_s2_q)
    prefetch_grp |-> (pf_x_reg[3:1] == default_working_reg_map_pkg::W_PF_X0[3:1]) &&
                     (pf_y_reg[3:1] == default_working_reg_map_pkg::W_PF_Y0[3:1]) &&
                     (pf_ofs_reg == default_working_reg_map_pkg::W_PF_OFS);
  endproperty
  a_pf_ptrs: assert property (p_pf_ptrs) else $error("prefetch pointer mapping wrong");

  property p_wb_dest;
    @(posedge core_clk) disable iff (!rst_s2_q)
    (cls == default_working_reg_map_pkg::OP_MAC) |=> default_working_reg_q[13] == $past(wb_data);
  endproperty
  a_wb_dest: assert property (p_wb_dest) else $error("accumulator write-back not in W13");

  property p_mixed_sign;
    @(posedge core_clk) disable iff (!rst_s2_q)
    (prefetch_grp && mult_sign_select == 2'h2) |-> !op_a_signed && op_b_signed;
  endproperty
  a_mixed_sign: assert property (p_mixed_sign) else $error("mixed-sign selection wrong");

  property p_uniform_sign;
    @(posedge core_clk) disable iff (!rst_s2_q)
    (mult_sign_select != default_working_reg_map_pkg::SIGN_MIXED) |->
      (op_a_signed == (mult_sign_select != default_working_reg_map_pkg::SIGN_UNS)) &&
      (op_b_signed == (mult_sign_select != default_working_reg_map_pkg::SIGN_UNS));
  endproperty
  a_uniform_sign: assert property (p_uniform_sign) else $error("uniform sign not applied");

  sequence s_word_mul;
    (cls == default_working_reg_map_pkg::OP_FILE_MUL) && !byte_mode;
  endsequence
  property p_word_mul;
    @(posedge core_clk) disable iff (!rst_s2_q)
    s_word_mul |=> {default_working_reg_q[3], default_working_reg_q[2]} == $past(file_rdata) * $past(default_working_reg_q[0]);
  endproperty
  a_word_mul: assert property (p_word_mul) else $error("word file multiply result wrong");

  property p_byte_mul;
    @(posedge core_clk) disable iff (!rst_s2_q)
    ((cls == default_working_reg_map_pkg::OP_FILE_MUL) && byte_mode && !sp_we && !fp_we)
      |=> $stable(default_working_reg_q[3]);
  endproperty
  a_byte_mul: assert property (p_byte_mul) else $error("byte file multiply touched W3");

  property p_byte_move;
    @(posedge core_clk) disable iff (!rst_s2_q)
    ((cls == default_working_reg_map_pkg::OP_MOV_WN2F) && byte_mode) |=> illegal_op && !file_we;
  endproperty
  a_byte_move: assert property (p_byte_move) else $error("byte move by general form");

  property p_default_reg;
    @(posedge core_clk) disable iff (!rst_s2_q)
    (cls == default_working_reg_map_pkg::OP_ALU_F) |-> op_a_reg == 4'h0;
  endproperty
  a_default_reg: assert property (p_default_reg) else $error("file op not using W0");
endmodule
`default_nettype wire

// File: tb/testbench.sv
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic                    core_clk, rst_b, op_valid, byte_mode, sp_we, fp_we;
  default_working_reg_map_pkg::op_class_t op_class;
  logic [3:0]              wn_sel, wm_sel, rd_sel;
  logic [1:0]              mac_op_sel, pf_x_sel, pf_y_sel, mult_sign_select;
  logic [15:0]             file_rdata, wb_data, sp_next, fp_next, rd_data, file_wdata;
  logic                    file_we, file_byte, op_a_signed, op_b_signed, illegal_op;
  logic [3:0]              op_a_reg, op_b_reg, pf_x_reg, pf_y_reg, pf_ofs_reg, acc_wb_reg;
  int                      error_cnt, tests_run, cyc;

  default_working_reg_operand_map i_dut
  (
    .core_clk, .rst_b, .op_class, .op_valid, .byte_mode, .wn_sel, .wm_sel, .mac_op_sel,
    .pf_x_sel, .pf_y_sel, .mult_sign_select, .file_rdata, .wb_data, .sp_next, .sp_we,
    .fp_next, .fp_we, .rd_sel, .rd_data, .file_wdata, .file_we, .file_byte, .op_a_signed,
    .op_b_signed, .op_a_reg, .op_b_reg, .pf_x_reg, .pf_y_reg, .pf_ofs_reg, .acc_wb_reg,
    .illegal_op
  );

  always #4 core_clk = ~core_clk;

  // cuts a hang short
  always @(posedge core_clk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      error_cnt++;
      final_report();
    end
  end

  task final_report();
    $display("mismatches %0d, checks %0d", error_cnt, tests_run);
    if (error_cnt == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task chk_reg(input logic [3:0] r, input logic [15:0] e);
    rd_sel = r;
    #0.1;
    chk(rd_data, e);
  endtask

  // one instruction, launched one cycle after the previous one ended
  task issue(input default_working_reg_map_pkg::op_class_t c, input logic bm, input logic [3:0] wn,
             input logic [15:0] fd, input logic [15:0] wb);
    @(posedge core_clk);
    #1;
    op_class = c;
    byte_mode = bm;
    wn_sel = wn;
    wm_sel = wn;
    file_rdata = fd;
    wb_data = wb;
    op_valid = 1'b1;
    @(posedge core_clk);
    #1;
    op_valid = 1'b0;
  endtask

  task t_load();
    for (int r = 0; r < 16; r++)
      chk_reg(4'(r), 16'h0000);
    for (int r = 0; r < 16; r++)
      issue(default_working_reg_map_pkg::OP_MOV_F2WN, 1'b0, 4'(r), {12'hA50, 4'(r)}, 16'h0000);
    for (int r = 0; r < 16; r++)
      chk_reg(4'(r), {12'hA50, 4'(r)});
  endtask

  task t_moves();
    issue(default_working_reg_map_pkg::OP_MOV_W2F, 1'b0, 4'h7, 16'h0000, 16'h0000);
    chk(16'(file_we), 16'h0001);
    chk(file_wdata, 16'hA500);
    chk(16'(file_byte), 16'h0000);
    issue(default_working_reg_map_pkg::OP_MOV_W2F, 1'b1, 4'h7, 16'h0000, 16'h0000);
    chk(16'(file_byte), 16'h0001);
    chk(16'(file_wdata[7:0]), 16'h0000);
    issue(default_working_reg_map_pkg::OP_MOV_WN2F, 1'b0, 4'h9, 16'h0000, 16'h0000);
    chk(file_wdata, 16'hA509);
    issue(default_working_reg_map_pkg::OP_MOV_F2WN, 1'b1, 4'h6, 16'h1234, 16'h0000);
    chk(16'(illegal_op), 16'h0001);
    chk_reg(4'h6, 16'hA506);
    issue(default_working_reg_map_pkg::OP_MOV_WN2F, 1'b1, 4'h6, 16'h0000, 16'h0000);
    chk(16'(illegal_op), 16'h0001);
    chk(16'(file_we), 16'h0000);
  endtask

  task t_fmul();
    issue(default_working_reg_map_pkg::OP_MOV_F2W, 1'b0, 4'h9, 16'h7705, 16'h0000);
    chk_reg(4'h0, 16'h7705);
    issue(default_working_reg_map_pkg::OP_FILE_MUL, 1'b1, 4'h9, 16'h1255, 16'h0000);
    chk_reg(4'h2, 16'h01A9);
    chk_reg(4'h3, 16'hA503);
    issue(default_working_reg_map_pkg::OP_FILE_MUL, 1'b0, 4'h9, 16'h1255, 16'h0000);
    chk_reg(4'h3, 16'h0885);
    chk_reg(4'h2, 16'hDEA9);
    issue(default_working_reg_map_pkg::OP_MOV_F2W, 1'b0, 4'h9, 16'hFFFF, 16'h0000);
    issue(default_working_reg_map_pkg::OP_FILE_MUL, 1'b0, 4'h9, 16'hFFFF, 16'h0000);
    chk_reg(4'h3, 16'hFFFE);
    chk_reg(4'h2, 16'h0001);
    issue(default_working_reg_map_pkg::OP_MOV_F2W, 1'b1, 4'h9, 16'h1234, 16'h0000);
    chk_reg(4'h0, 16'hFF34);
  endtask

  task t_regs();
    issue(default_working_reg_map_pkg::OP_MUL_WW, 1'b0, 4'h5, 16'h5555, 16'h4444);
    chk_reg(4'h4, 16'h4444);
    chk_reg(4'h5, 16'h5555);
    issue(default_working_reg_map_pkg::OP_ACC_GEN, 1'b0, 4'h3, 16'h0000, 16'h3C3C);
    chk_reg(4'h3, 16'h3C3C);
    chk_reg(4'hD, 16'hA50D);
    issue(default_working_reg_map_pkg::OP_ACC_GEN, 1'b0, 4'hF, 16'h0000, 16'h7E7E);
    chk_reg(4'hF, 16'h7E7E);
    @(posedge core_clk);
    #1;
    sp_next = 16'h1234;
    fp_next = 16'h5678;
    sp_we = 1'b1;
    fp_we = 1'b1;
    op_class = default_working_reg_map_pkg::OP_ACC_GEN;
    op_valid = 1'b1;
    @(posedge core_clk);
    #1;
    sp_we = 1'b0;
    fp_we = 1'b0;
    op_valid = 1'b0;
    chk_reg(4'hF, 16'h1234);
    chk_reg(4'hE, 16'h5678);
  endtask

  task t_map();
    @(posedge core_clk);
    #1;
    mult_sign_select = 2'h2;
    op_valid = 1'b1;
    for (int c = 1; c <= 8; c++)
      for (int s = 0; s < 4; s++)
      begin
        op_class = default_working_reg_map_pkg::op_class_t'(5'(c));
        mac_op_sel = 2'(s);
        pf_x_sel = {1'b0, 1'(s % 2)};
        pf_y_sel = {1'b0, 1'(s / 2)};
        #0.1;
        chk(16'(op_a_reg), 16'(4 + 2 * (s % 2)));
        chk(16'(op_b_reg), 16'(5 + 2 * (s / 2)));
        chk(16'(pf_x_reg), 16'(8 + s % 2));
        chk(16'(pf_y_reg), 16'(10 + s / 2));
        chk(16'(pf_ofs_reg), 16'h000C);
        chk(16'(acc_wb_reg), 16'h000D);
        chk(16'(op_a_signed), 16'h0000);
        chk(16'(op_b_signed), 16'h0001);
        @(posedge core_clk);
        #1;
      end
    op_valid = 1'b0;
    issue(default_working_reg_map_pkg::OP_MAC, 1'b0, 4'h0, 16'h0000, 16'hBEEF);
    chk_reg(4'hD, 16'hBEEF);
  endtask

  task t_sign();
    @(posedge core_clk);
    #1;
    op_class = default_working_reg_map_pkg::OP_DSP_MPY;
    op_valid = 1'b1;
    for (int m = 0; m < 4; m++)
      if (m != 2)
      begin
        mult_sign_select = 2'(m);
        mac_op_sel = 2'(m);
        @(posedge core_clk);
        #1;
        chk(16'(op_a_signed), 16'(m != 1));
        chk(16'(op_b_signed), 16'(m != 1));
      end
    op_valid = 1'b0;
  endtask

  // implied pointers and default register outside the prefetch group
  task t_implied();
    @(posedge core_clk);
    #1;
    op_valid = 1'b1;
    op_class = default_working_reg_map_pkg::OP_STACK;
    wn_sel = 4'h6;
    wm_sel = 4'h9;
    wb_data = 16'h1357;
    #0.1;
    chk(16'(op_a_reg), 16'h000F);
    chk(16'(op_b_reg), 16'h0006);
    @(posedge core_clk);
    #1;
    op_class = default_working_reg_map_pkg::OP_FRAME;
    #0.1;
    chk(16'(op_a_reg), 16'h000F);
    chk(16'(op_b_reg), 16'h000E);
    @(posedge core_clk);
    #1;
    op_class = default_working_reg_map_pkg::OP_ALU_F;
    #0.1;
    chk(16'(op_a_reg), 16'h0000);
    chk(16'(pf_ofs_reg), 16'h0000);
    @(posedge core_clk);
    #1;
    op_valid = 1'b0;
    chk_reg(4'h9, 16'h1357);
  endtask

  initial
  begin
    core_clk = 1'b0;
    rst_b = 1'b0;
    op_valid = 1'b0;
    byte_mode = 1'b0;
    sp_we = 1'b0;
    fp_we = 1'b0;
    op_class = default_working_reg_map_pkg::OP_NONE;
    wn_sel = 4'h0;
    wm_sel = 4'h0;
    rd_sel = 4'h0;
    mac_op_sel = 2'h0;
    pf_x_sel = 2'h0;
    pf_y_sel = 2'h0;
    mult_sign_select = 2'h0;
    file_rdata = 16'h0000;
    wb_data = 16'h0000;
    sp_next = 16'h0000;
    fp_next = 16'h0000;
    repeat (10) @(posedge core_clk);
    #1;
    rst_b = 1'b1;
    repeat (3) @(posedge core_clk);
    #1;
    t_load();
    t_moves();
    t_fmul();
    t_regs();
    t_map();
    t_sign();
    t_implied();
    final_report();
  end
endmodule
`default_nettype wire
